// >>> verilog/mbc_pkg.sv
package mbc_pkg;
	// Register offsets of the two command registers
	localparam logic [11:0] MBC_OFS_OVERRIDE = 12'h1e4;
	localparam logic [11:0] MBC_OFS_IMMED    = 12'h4d0;
	// Remaining registers grouped in their own block
	localparam logic [11:0] MBC_OFS_PRESENT  = 12'h500;
	localparam logic [11:0] MBC_OFS_STATE    = 12'h504;
	localparam logic [11:0] MBC_OFS_FAULT    = 12'h508;
	localparam logic [11:0] MBC_OFS_VTHRESH  = 12'h50c;
	localparam logic [11:0] MBC_OFS_DWELL    = 12'h510;
	// Reset values
	localparam logic [7:0]  MBC_RST_OVERRIDE = 8'h00;
	localparam logic [7:0]  MBC_RST_IMMED    = 8'h00;
	localparam logic        MBC_RST_PRESENT  = 1'b0;
	localparam logic [15:0] MBC_RST_VTHRESH  = 16'h0000;
	localparam logic [15:0] MBC_RST_DWELL    = 16'h0000;
	// Override command codes
	localparam logic [7:0]  MBC_OVR_AUTO     = 8'h00;
	localparam logic [7:0]  MBC_OVR_RELEASE  = 8'h01;
	localparam logic [7:0]  MBC_OVR_APPLY    = 8'h02;
	// Status codes
	localparam logic [1:0]  MBC_ST_RELEASED  = 2'h1;
	localparam logic [1:0]  MBC_ST_APPLIED   = 2'h2;
	// Fault register bit positions
	localparam int          MBC_FLT_OPEN     = 0;
	localparam int          MBC_FLT_SHORT    = 1;
	localparam int          MBC_FLT_MISSING  = 2;
	// Timing
	localparam int          MBC_CLK_HZ       = 40000000;
	localparam int          MBC_POLL_MS      = 16;
	localparam int          MBC_POLL_CYC     = MBC_CLK_HZ / 1000 * MBC_POLL_MS;
	localparam int          MBC_MS_CYC       = MBC_CLK_HZ / 1000;
	// Register access bundle
	typedef struct packed {
		logic        wr;
		logic        rd;
		logic [11:0] addr;
		logic [15:0] wdata;
	} mbc_req_t;
	// Brake circuit indications
	typedef struct packed {
		logic open_ckt;
		logic short_ckt;
		logic missing;
	} mbc_ckt_t;
	// Digital input request
	typedef struct packed {
		logic release_req;
		logic apply_req;
	} mbc_din_t;
endpackage : mbc_pkg

// >>> verilog/mbc_tick.sv
`timescale 1ns/1ps
`default_nettype none
// Periodic strobe: one pulse each PERIOD enabled cycles
module mbc_tick #(
	parameter int PERIOD = 1000
) (
	// Clock and reset
	input  wire logic clk_i,
	input  wire logic rst_i,
	input  wire logic ce_i,
	// Strobe
	input  wire logic run_i,
	output logic      tick_o
);
	localparam int W = (PERIOD > 1) ? $clog2(PERIOD) : 1;
	// A zero period would never strobe
	if (PERIOD < 1) begin : g_bad_period
		$error("mbc_tick: PERIOD must be at least 1");
	end
	logic [W-1:0] cnt_r;   // Cycles since last strobe
	logic [W-1:0] cnt_nxt;
	// Count up, wrap at PERIOD-1; restart when idle so timing starts clean
	always_comb begin
		cnt_nxt = cnt_r;
		if (!run_i) begin
			cnt_nxt = '0;
		end else if (cnt_r == W'(PERIOD - 1)) begin
			cnt_nxt = '0;
		end else begin
			cnt_nxt = cnt_r + W'(1);
		end
	end
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cnt_r <= '0;
		end else if (ce_i) begin
			cnt_r <= cnt_nxt;
		end
	end
	assign tick_o = ce_i && run_i && (cnt_r == W'(PERIOD - 1));
endmodule : mbc_tick
`default_nettype wire

// >>> verilog/mbc_brake_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
// Holding-brake supervisor for one drive axis
module mbc_brake_ctrl #(
	parameter int POLL_CYC = mbc_pkg::MBC_POLL_CYC, // 16 ms poll period
	parameter int MS_CYC   = mbc_pkg::MBC_MS_CYC    // Cycles per millisecond
) (
	// Clock, reset, enable
	input  wire logic              clk_i,
	input  wire logic              rst_i,
	input  wire logic              ce_i,
	// Parameter register port
	input  wire mbc_pkg::mbc_req_t req_i,
	output logic [15:0]            rdata_o,
	output logic                   rvalid_o,
	// Drive state
	input  wire logic              drive_en_i,
	input  wire logic [15:0]       vel_abs_i,
	// Brake circuit and digital input
	input  wire mbc_pkg::mbc_ckt_t ckt_i,
	input  wire mbc_pkg::mbc_din_t din_i,
	// Brake driver and fault
	output logic                   brake_release_o,
	output logic                   fault_o
);
	import mbc_pkg::*;
	// Refuse periods the strobe counters cannot count
	if (POLL_CYC < 1 || MS_CYC < 1) begin : g_bad_period
		$error("mbc_brake_ctrl: periods must be positive");
	end

	// Brake controller states
	typedef enum logic [1:0] {
		MBC_S_HELD    = 2'b00, // Drive off, brake applied
		MBC_S_RUN     = 2'b01, // Drive on, brake released
		MBC_S_DWELL   = 2'b10  // Disabled, waiting for standstill
	} mbc_state_t;

	// Registers
	logic [7:0]  ovr_r, ovr_nxt;          // Override command
	logic [7:0]  imm_r, imm_nxt;          // Immediate-apply option
	logic        pres_r, pres_nxt;        // Brake present flag
	logic [15:0] vth_r, vth_nxt;          // Stop velocity threshold
	logic [15:0] dwell_r, dwell_nxt;      // Stop dwell time, ms
	logic [2:0]  flt_r, flt_nxt;          // Sticky circuit faults
	logic [15:0] rdata_nxt;
	mbc_state_t  st_r, st_nxt;            // Auto control state
	logic [15:0] ms_r, ms_nxt;            // Milliseconds below threshold
	logic        rel_r, rel_nxt;          // Final release output
	logic        ms_tick, poll_tick;
	logic [1:0]  state_code;              // Status code for readback

	// Absent brake reports released, else follow the output
	assign state_code = (rel_r || !pres_r) ? MBC_ST_RELEASED : MBC_ST_APPLIED;

	// Millisecond base for the dwell, runs only while waiting
	mbc_tick #(.PERIOD(MS_CYC)) u_ms (
		.clk_i  (clk_i),
		.rst_i  (rst_i),
		.ce_i   (ce_i),
		.run_i  (st_r == MBC_S_DWELL),
		.tick_o (ms_tick)
	);
	mbc_tick #(.PERIOD(POLL_CYC)) u_poll (
		.clk_i  (clk_i),
		.rst_i  (rst_i),
		.ce_i   (ce_i),
		.run_i  (1'b1),
		.tick_o (poll_tick)
	);

	// Register writes and fault capture
	always_comb begin
		ovr_nxt   = ovr_r;
		imm_nxt   = imm_r;
		pres_nxt  = pres_r;
		vth_nxt   = vth_r;
		dwell_nxt = dwell_r;
		flt_nxt   = flt_r;
		rdata_nxt = rdata_o;
		// Write to fault register clears bits set in data
		if (req_i.wr) begin
			unique case (req_i.addr)
				MBC_OFS_OVERRIDE: begin
					if (req_i.wdata[7:0] <= MBC_OVR_APPLY) begin
						ovr_nxt = req_i.wdata[7:0];
					end
				end
				MBC_OFS_IMMED:    imm_nxt   = {7'h00, req_i.wdata[0]};
				// Flag only declares presence, no effect on the brake output
				MBC_OFS_PRESENT:  pres_nxt  = req_i.wdata[0];
				MBC_OFS_VTHRESH:  vth_nxt   = req_i.wdata;
				MBC_OFS_DWELL:    dwell_nxt = req_i.wdata;
				MBC_OFS_FAULT:    flt_nxt   = flt_r & ~req_i.wdata[2:0];
				default: ;
			endcase
		end
		// Sample circuit indications on poll when present
		// Absent brake: indications ignored
		// Set wins over a concurrent clear
		if (poll_tick && pres_r) begin
			flt_nxt[MBC_FLT_OPEN]  = flt_nxt[MBC_FLT_OPEN]  | ckt_i.open_ckt;
			flt_nxt[MBC_FLT_SHORT] = flt_nxt[MBC_FLT_SHORT] | ckt_i.short_ckt;
			flt_nxt[MBC_FLT_MISSING] = flt_nxt[MBC_FLT_MISSING] | ckt_i.missing;
		end
		// Read data, unmapped reads zero
		if (req_i.rd) begin
			unique case (req_i.addr)
				MBC_OFS_OVERRIDE: rdata_nxt = {8'h00, ovr_r};
				MBC_OFS_IMMED:    rdata_nxt = {8'h00, imm_r};
				MBC_OFS_PRESENT:  rdata_nxt = {15'h0000, pres_r};
				MBC_OFS_STATE:    rdata_nxt = {14'h0000, state_code};
				MBC_OFS_FAULT:    rdata_nxt = {13'h0000, flt_r};
				MBC_OFS_VTHRESH:  rdata_nxt = vth_r;
				MBC_OFS_DWELL:    rdata_nxt = dwell_r;
				default:          rdata_nxt = 16'h0000;
			endcase
		end
	end

	// Automatic disable sequencing and output combination
	always_comb begin
		st_nxt  = st_r;
		ms_nxt  = ms_r;
		rel_nxt = rel_r;
		unique case (st_r)
			MBC_S_HELD: if (drive_en_i) st_nxt = MBC_S_RUN;
			MBC_S_RUN: begin
				if (!drive_en_i) begin
					st_nxt = imm_r[0] ? MBC_S_HELD : MBC_S_DWELL;
					ms_nxt = 16'h0000;
				end
			end
			MBC_S_DWELL: begin
				// Wait for velocity below threshold for dwell
				if (drive_en_i) begin
					st_nxt = MBC_S_RUN;
				end else if (imm_r[0] || (vel_abs_i < vth_r && ms_r >= dwell_r)) begin
					st_nxt = MBC_S_HELD;
				end else if (vel_abs_i >= vth_r) begin
					ms_nxt = 16'h0000;
				end else if (ms_tick && ms_r != 16'hffff) begin
					ms_nxt = ms_r + 16'h0001;
				end
			end
			default: st_nxt = MBC_S_HELD;
		endcase
		// Digital input path, overridden by a release or apply override
		rel_nxt = (st_nxt != MBC_S_HELD);
		if (din_i.apply_req) rel_nxt = 1'b0;
		else if (din_i.release_req) rel_nxt = 1'b1;
		if (ovr_r == MBC_OVR_RELEASE) rel_nxt = 1'b1;
		else if (ovr_r == MBC_OVR_APPLY) rel_nxt = 1'b0;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ovr_r    <= MBC_RST_OVERRIDE;
			imm_r    <= MBC_RST_IMMED;
			pres_r   <= MBC_RST_PRESENT;
			vth_r    <= MBC_RST_VTHRESH;
			dwell_r  <= MBC_RST_DWELL;
			flt_r    <= 3'h0;
			rdata_o  <= 16'h0000;
			rvalid_o <= 1'b0;
			st_r     <= MBC_S_HELD;
			ms_r     <= 16'h0000;
			rel_r    <= 1'b0;
		end else if (ce_i) begin
			ovr_r    <= ovr_nxt;
			imm_r    <= imm_nxt;
			pres_r   <= pres_nxt;
			vth_r    <= vth_nxt;
			dwell_r  <= dwell_nxt;
			flt_r    <= flt_nxt;
			rdata_o  <= rdata_nxt;
			rvalid_o <= req_i.rd;
			st_r     <= st_nxt;
			ms_r     <= ms_nxt;
			rel_r    <= rel_nxt;
		end
	end

	assign brake_release_o = rel_r;
	assign fault_o         = |flt_r;

	// Assertions
	// Immediate option reaches held state next cycle
	chk_imm_apply: assert property (@(posedge clk_i) disable iff (rst_i)
		(ce_i && st_r == MBC_S_RUN && !drive_en_i && imm_r[0]) |=> st_r == MBC_S_HELD)
		else $error("immediate apply missed");
	chk_ovr_apply: assert property (@(posedge clk_i) disable iff (rst_i)
		(ce_i && ovr_r == MBC_OVR_APPLY) |=> !brake_release_o)
		else $error("override apply ignored");
	chk_ovr_release: assert property (@(posedge clk_i) disable iff (rst_i)
		(ce_i && ovr_r == MBC_OVR_RELEASE) |=> brake_release_o)
		else $error("override release ignored");
	// No faults gathered while brake absent
	chk_absent_quiet: assert property (@(posedge clk_i) disable iff (rst_i)
		(!pres_r && !$past(pres_r) && !(req_i.wr && req_i.addr == MBC_OFS_PRESENT))
		|=> (flt_r & ~$past(flt_r)) == 3'h0)
		else $error("fault set while brake absent");
	// Present brake with open circuit latches fault
	chk_open_fault: assert property (@(posedge clk_i) disable iff (rst_i)
		(poll_tick && pres_r && ckt_i.open_ckt) |=> flt_r[MBC_FLT_OPEN])
		else $error("open circuit not latched");
	chk_missing_fault: assert property (@(posedge clk_i) disable iff (rst_i)
		(poll_tick && pres_r && ckt_i.missing) |=> fault_o)
		else $error("missing brake not flagged");
	// Dwell state releases brake with no override or input
	chk_dwell_rel: assert property (@(posedge clk_i) disable iff (rst_i)
		(ce_i && st_r == MBC_S_DWELL && !imm_r[0] && ovr_r == MBC_OVR_AUTO
		&& din_i == 2'b00 && vel_abs_i >= vth_r && !drive_en_i) |=> brake_release_o)
		else $error("brake applied during dwell");
	// Digital apply wins in automatic mode
	chk_din_apply: assert property (@(posedge clk_i) disable iff (rst_i)
		(ce_i && ovr_r == MBC_OVR_AUTO && din_i.apply_req) |=> !brake_release_o)
		else $error("digital apply ignored");
	chk_absent_status: assert property (@(posedge clk_i) disable iff (rst_i)
		(ce_i && req_i.rd && req_i.addr == MBC_OFS_STATE && !pres_r)
		|=> rdata_o == {14'h0000, MBC_ST_RELEASED})
		else $error("absent brake not read as released");
endmodule : mbc_brake_ctrl
`default_nettype wire

// >>> test/mbc_brake_model.sv
`timescale 1ns/1ps
`default_nettype none
// Brake coil and its sensing circuit as the supervisor sees it
module mbc_brake_model (
	// Wiring condition chosen by the scenario
	input  wire logic           connected_i,
	input  wire logic           open_i,
	input  wire logic           short_i,
	// Indications back to the supervisor
	output var mbc_pkg::mbc_ckt_t ckt_o
);
	import mbc_pkg::*;
	// Indications are plain levels; an absent brake shows only as missing,
	// so open and short stay separate faults for the supervisor to tell apart
	always_comb begin
		ckt_o.open_ckt  = open_i & connected_i;
		ckt_o.short_ckt = short_i & connected_i;
		ckt_o.missing   = ~connected_i;
	end
endmodule : mbc_brake_model
`default_nettype wire

// >>> test/motor_brake_control_bench.sv
`timescale 1ns/1ps
`default_nettype none
// Self-checking bench for the holding-brake supervisor
module motor_brake_control_bench;
	import mbc_pkg::*;
	logic clk_i = 1'b0;             // 40 MHz system clock
	logic rst_i = 1'b1;             // Synchronous reset
	logic ce_i = 1'b1;              // Enabled except during the freeze in t_din
	mbc_req_t req = '0;             // Register strobes
	logic drive_en = 1'b0;          // Drive enable level
	logic [15:0] vel = 16'h01f4;    // Speed magnitude, starts fast
	mbc_din_t din = '0;             // Digital input requests
	logic connected = 1'b1;         // Brake wired in
	logic open_f = 1'b0;            // Open coil injection
	logic short_f = 1'b0;           // Shorted coil injection
	mbc_ckt_t ckt;                  // Model indications
	logic [15:0] rdata;             // Read data
	logic rvalid;                   // Read strobe
	logic brake_rel;                // Brake driver
	logic fault;                    // Fault summary
	logic [15:0] d;                 // Scratch read value
	int num_errors = 0;             // Mismatches
	int n_compared = 0;             // Comparisons
	// Short counts keep polls and dwell quick
	mbc_brake_ctrl #(.POLL_CYC(16), .MS_CYC(4)) DUT (.clk_i(clk_i), .rst_i(rst_i),
		.ce_i(ce_i), .req_i(req), .rdata_o(rdata), .rvalid_o(rvalid),
		.drive_en_i(drive_en), .vel_abs_i(vel), .ckt_i(ckt), .din_i(din),
		.brake_release_o(brake_rel), .fault_o(fault));
	mbc_brake_model partner (.connected_i(connected), .open_i(open_f),
		.short_i(short_f), .ckt_o(ckt));
	// Clock generator
	initial begin
		forever #12.5 clk_i = ~clk_i;
	end
	// Compare and count
	task chk(input logic [15:0] g, input logic [15:0] e);
		n_compared++;
		if (g !== e) begin
			$display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
			num_errors++;
		end
	endtask : chk
	// Wait whole cycles
	task cyc(input int n);
		repeat (n) @(posedge clk_i);
	endtask : cyc
	// One-cycle write strobe
	task wr(input logic [11:0] a, input logic [15:0] v);
		@(posedge clk_i);
		req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: v};
		@(posedge clk_i);
		req <= '0;
	endtask : wr
	// Read with a bounded wait for the answer
	task rd(input logic [11:0] a, output logic [15:0] v);
		int n;
		@(posedge clk_i);
		req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
		@(posedge clk_i);
		req <= '0;
		// Answer launched at the taking edge is read at the next one
		@(posedge clk_i);
		n = 0;
		while (rvalid !== 1'b1 && n < 4) begin
			@(posedge clk_i);
			n++;
		end
		chk({15'h0000, rvalid}, 16'h0001);
		v = rdata;
	endtask : rd
	// Read a register and compare
	task rchk(input logic [11:0] a, input logic [15:0] e);
		rd(a, d);
		chk(d, e);
	endtask : rchk
	// Reset values and an unmapped place
	task t_reset;
		chk({15'h0, brake_rel}, 16'h0000);
		chk({15'h0, fault}, 16'h0000);
		rchk(MBC_OFS_OVERRIDE, {8'h00, MBC_RST_OVERRIDE});
		rchk(MBC_OFS_IMMED, {8'h00, MBC_RST_IMMED});
		rchk(MBC_OFS_PRESENT, {15'h0000, MBC_RST_PRESENT});
		// No brake declared yet, so the status reads released
		rchk(MBC_OFS_STATE, {14'h0, MBC_ST_RELEASED});
		rchk(12'h7fc, 16'h0000);
	endtask : t_reset
	// Presence flag, polled faults, masking when absent
	task t_present;
		wr(MBC_OFS_PRESENT, 16'h0001);
		cyc(2);
		chk({15'h0, brake_rel}, 16'h0000);
		rchk(MBC_OFS_STATE, {14'h0, MBC_ST_APPLIED});
		connected <= 1'b0;
		cyc(40);
		chk({15'h0, fault}, 16'h0001);
		rchk(MBC_OFS_FAULT, 16'h0004);
		connected <= 1'b1;
		wr(MBC_OFS_FAULT, 16'h0007);
		cyc(2);
		chk({15'h0, fault}, 16'h0000);
		open_f <= 1'b1;
		short_f <= 1'b1;
		// Any 16 consecutive edges hold exactly one poll
		cyc(17);
		chk({15'h0, fault}, 16'h0001);
		cyc(23);
		rchk(MBC_OFS_FAULT, 16'h0003);
		wr(MBC_OFS_PRESENT, 16'h0000);
		wr(MBC_OFS_FAULT, 16'h0007);
		cyc(40);
		rchk(MBC_OFS_FAULT, 16'h0000);
		chk({15'h0, fault}, 16'h0000);
		open_f <= 1'b0;
		short_f <= 1'b0;
	endtask : t_present
	// Immediate apply on disable at full speed
	task t_immed;
		wr(MBC_OFS_IMMED, 16'h0001);
		rchk(MBC_OFS_IMMED, 16'h0001);
		drive_en <= 1'b1;
		cyc(3);
		chk({15'h0, brake_rel}, 16'h0001);
		drive_en <= 1'b0;
		// Held state and applied output one edge after the disable
		cyc(2);
		chk({15'h0, brake_rel}, 16'h0000);
	endtask : t_immed
	// Slow-speed dwell before applying
	task t_dwell;
		wr(MBC_OFS_IMMED, 16'h0000);
		wr(MBC_OFS_VTHRESH, 16'h0064);
		wr(MBC_OFS_DWELL, 16'h0003);
		rchk(MBC_OFS_DWELL, 16'h0003);
		drive_en <= 1'b1;
		cyc(3);
		drive_en <= 1'b0;
		cyc(40);
		chk({15'h0, brake_rel}, 16'h0001);
		// Declaring the brake while it is released must not apply it
		wr(MBC_OFS_PRESENT, 16'h0001);
		cyc(2);
		chk({15'h0, brake_rel}, 16'h0001);
		rchk(MBC_OFS_STATE, {14'h0, MBC_ST_RELEASED});
		vel <= 16'h000a;
		// Three 4-cycle ms ticks needed; at most two by now
		cyc(8);
		chk({15'h0, brake_rel}, 16'h0001);
		cyc(17);
		chk({15'h0, brake_rel}, 16'h0000);
		rchk(MBC_OFS_STATE, {14'h0, MBC_ST_APPLIED});
	endtask : t_dwell
	// Override codes, one refused value
	task t_override;
		wr(MBC_OFS_OVERRIDE, {8'h00, MBC_OVR_RELEASE});
		cyc(2);
		chk({15'h0, brake_rel}, 16'h0001);
		rchk(MBC_OFS_STATE, {14'h0, MBC_ST_RELEASED});
		drive_en <= 1'b1;
		wr(MBC_OFS_OVERRIDE, {8'h00, MBC_OVR_APPLY});
		cyc(2);
		chk({15'h0, brake_rel}, 16'h0000);
		rchk(MBC_OFS_STATE, {14'h0, MBC_ST_APPLIED});
		wr(MBC_OFS_OVERRIDE, 16'h0003);
		rchk(MBC_OFS_OVERRIDE, {8'h00, MBC_OVR_APPLY});
		wr(MBC_OFS_OVERRIDE, {8'h00, MBC_OVR_AUTO});
		cyc(2);
		chk({15'h0, brake_rel}, 16'h0001);
	endtask : t_override
	// Digital input path with override left on auto
	task t_din;
		din <= '{release_req: 1'b0, apply_req: 1'b1};
		cyc(2);
		chk({15'h0, brake_rel}, 16'h0000);
		rchk(MBC_OFS_STATE, {14'h0, MBC_ST_APPLIED});
		drive_en <= 1'b0;
		din <= '{release_req: 1'b1, apply_req: 1'b0};
		cyc(2);
		chk({15'h0, brake_rel}, 16'h0001);
		din <= '0;
		cyc(30);
		chk({15'h0, brake_rel}, 16'h0000);
		// Enable low freezes the controller, so a new enable waits
		ce_i <= 1'b0;
		drive_en <= 1'b1;
		cyc(4);
		chk({15'h0, brake_rel}, 16'h0000);
		ce_i <= 1'b1;
		cyc(3);
		chk({15'h0, brake_rel}, 16'h0001);
	endtask : t_din
	// Verdict and end of run
	task end_sim;
		$display("Comparisons %0d, mismatches %0d", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : end_sim
	// Main sequence
	initial begin
		cyc(16);
		rst_i <= 1'b0;
		t_reset();
		t_present();
		t_immed();
		t_dwell();
		t_override();
		t_din();
		end_sim();
	end
	// Watchdog well beyond the few hundred cycles the tests need
	initial begin
		#500000;
		num_errors++;
		end_sim();
	end
endmodule : motor_brake_control_bench
`default_nettype wire
